// ---- psc_pll_regs.sv ----
/*
 * Byte-wide configuration register bank of a fractional-N PLL: reference
 * doubler, charge-pump gain, integer and fractional divider, modulator
 * and loop-filter R2 code, with decoded control outputs.
 * Assumes a single-master register port: one-cycle strobes, never both
 * at once, read data valid in the cycle after the read strobe only.
 */
// Overview of operation
// RL1: bit 4 of doubler/cp register enables primary reference doubler, resets to 1.
// RL2: cp gain in bits 3:0 resets to 8; codes 1-7 step 0.4 mA, 8 is 6.4 mA.
// RL3: integer divider is 12 bits; codes 0 and 1 divide by one.
// RL4: divider bits 11:8 sit in bits 3:0 of high register; 7:4 reserved.
// RL5: divider bits 7:0 fill the low register, reset 0x66, ratio 102.
// RL6: 22-bit numerator over three registers, top holds bits 21:16, reset 0.
// RL7: 22-bit denominator over three registers, top holds bits 21:16, reset 0.
// RL8: dither select in bits 3:2: weak, medium, strong, off; resets to off.
// RL9: modulator order in bits 1:0: integer, first to third order; resets 0.
// RL10: six-bit loop-filter R2 code resets to 0x24.
// RL11: reserved bits read zero and ignore writes, except bit 5 of doubler/cp register, which stores; fields read back.
`timescale 1ns/1ps
`default_nettype none
module psc_pll_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [psc_pkg::PSC_AW-1:0] addr,
    input wire logic [psc_pkg::PSC_DW-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [psc_pkg::PSC_DW-1:0] rdata,
    // reference and charge pump
    output logic primary_ref_doubler_en,
    output logic [3:0] cp_gain_code,
    output logic [6:0] cp_current,
    // dividers
    output logic [11:0] int_feedback_divider,
    output logic [11:0] int_divide_ratio,
    output logic [21:0] frac_numerator,
    output logic [21:0] frac_denominator,
    // modulator and loop filter
    output logic [1:0] modulator_dither_select,
    output logic [1:0] modulator_order,
    output logic dither_active,
    output logic frac_mode,
    output logic [5:0] loop_filter_r2_code
);
    import psc_pkg::*;

    logic [7:0] reg_q [PSC_NREG];
    logic [PSC_NREG-1:0] hit;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic dth_q;
    logic dth_d;
    logic frac_q;
    logic frac_d;

    // one register per entry; a write lands only on its own offset
    genvar gi;
    generate
        for (gi = 0; gi < PSC_NREG; gi = gi + 1) begin : g_reg
            assign hit[gi] = (addr == PSC_OFS[gi]);
            psc_field_reg #(
                .RST_VAL(PSC_RST[gi]),
                .WR_MASK(PSC_MSK[gi])
            ) u_reg (
                .clk(clk),
                .rstn(rstn),
                .we(wr_en && hit[gi]),
                .wdata(wdata),
                .q(reg_q[gi])
            );
        end
    endgenerate

    // field extraction from the stored bytes
    assign primary_ref_doubler_en = reg_q[PSC_R_DBLCP][PSC_DBL_BIT]; // RL1
    assign cp_gain_code = reg_q[PSC_R_DBLCP][PSC_CP_MSB:0]; // RL2
    assign int_feedback_divider = {
        reg_q[PSC_R_NHI][PSC_NHI_MSB:0], // RL4
        reg_q[PSC_R_NLO]}; // RL5
    assign frac_numerator = {
        reg_q[PSC_R_NUM2][PSC_TOP_MSB:0],
        reg_q[PSC_R_NUM1],
        reg_q[PSC_R_NUM0]}; // RL6
    assign frac_denominator = {
        reg_q[PSC_R_DEN2][PSC_TOP_MSB:0],
        reg_q[PSC_R_DEN1],
        reg_q[PSC_R_DEN0]}; // RL7
    assign modulator_dither_select =
        reg_q[PSC_R_MOD][PSC_DTH_MSB:PSC_DTH_LSB]; // RL8
    assign modulator_order = reg_q[PSC_R_MOD][PSC_ORD_MSB:0]; // RL9
    assign loop_filter_r2_code = reg_q[PSC_R_LFR2][PSC_R2_MSB:0]; // RL10

    // ratio and current decode, registered
    psc_div_decode u_dec (
        .clk(clk),
        .rstn(rstn),
        .div_code(int_feedback_divider),
        .cp_code(cp_gain_code),
        .div_ratio(int_divide_ratio),
        .cp_current(cp_current)
    );

    // modulator mode flags
    always_comb begin
        dth_d = (psc_dither_t'(modulator_dither_select) != PSC_DTH_OFF); // RL8
        frac_d = (psc_order_t'(modulator_order) != PSC_ORD_INT); // RL9
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dth_q <= 1'b0;
            frac_q <= 1'b0;
        end else begin
            dth_q <= dth_d;
            frac_q <= frac_d;
        end
    end

    assign dither_active = dth_q;
    assign frac_mode = frac_q;

    // read mux: unmapped offsets and idle cycles give zero
    always_comb begin
        rdata_d = 8'h00;
        if (rd_en) begin
            for (int i = 0; i < PSC_NREG; i++) begin
                if (hit[i]) begin
                    rdata_d = reg_q[i]; // RL11
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // first cycle after reset release
    logic first_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    property p_rst_doubler;
        first_q |-> primary_ref_doubler_en && cp_gain_code == 4'h8;
    endproperty
    a_rst_doubler: assert property (p_rst_doubler) // RL1
        else $error("doubler or cp gain reset value wrong");

    property p_doubler_wr;
        wr_en && addr == PSC_OFS_DBLCP |=>
            primary_ref_doubler_en == $past(wdata[PSC_DBL_BIT]);
    endproperty
    a_doubler_wr: assert property (p_doubler_wr) // RL1
        else $error("doubler enable did not follow write");

    // skip the cycle in which the decode flops still hold their reset zero
    property p_cp_current;
        !first_q |=> ($past(cp_gain_code) == PSC_CP_CODE_HI) ?
            (cp_current == PSC_CP_HI) :
            ($past(cp_gain_code) <= PSC_CP_STEP_MAX) ?
                (cp_current == 7'($past(cp_gain_code) * 4)) :
                (cp_current == 7'h00);
    endproperty
    a_cp_current: assert property (p_cp_current) // RL2
        else $error("charge-pump current decode wrong");

    property p_div_ratio;
        !first_q |=> ($past(int_feedback_divider) <= 12'h001) ?
            (int_divide_ratio == 12'h001) :
            (int_divide_ratio == $past(int_feedback_divider));
    endproperty
    a_div_ratio: assert property (p_div_ratio) // RL3
        else $error("integer divide ratio wrong");

    property p_nhi_wr;
        wr_en && addr == PSC_OFS_NHI |=>
            int_feedback_divider[11:8] == $past(wdata[3:0]);
    endproperty
    a_nhi_wr: assert property (p_nhi_wr) // RL4
        else $error("divider high nibble did not follow write");

    property p_nhi_rsvd;
        rd_en && addr == PSC_OFS_NHI |=> rdata[7:4] == 4'h0;
    endproperty
    a_nhi_rsvd: assert property (p_nhi_rsvd) // RL4
        else $error("divider high reserved bits not zero");

    // ratio flop loads one edge after release, so look when first_q drops
    property p_rst_div;
        first_q ##1 !first_q |-> int_feedback_divider == 12'h066 &&
            int_divide_ratio == 12'd102;
    endproperty
    a_rst_div: assert property (p_rst_div) // RL5
        else $error("divider reset value wrong");

    property p_nlo_wr;
        wr_en && addr == PSC_OFS_NLO |=>
            int_feedback_divider[7:0] == $past(wdata);
    endproperty
    a_nlo_wr: assert property (p_nlo_wr) // RL5
        else $error("divider low byte did not follow write");

    property p_num_top;
        wr_en && addr == PSC_OFS_NUM2 |=>
            frac_numerator[21:16] == $past(wdata[5:0]) &&
            $stable(frac_numerator[15:0]);
    endproperty
    a_num_top: assert property (p_num_top) // RL6
        else $error("numerator top bits did not follow write");

    property p_num_hold;
        !wr_en |=> $stable(frac_numerator) && $stable(frac_denominator);
    endproperty
    a_num_hold: assert property (p_num_hold) // RL6
        else $error("fraction changed without a write");

    property p_den_mid;
        wr_en && addr == PSC_OFS_DEN1 |=>
            frac_denominator[15:8] == $past(wdata);
    endproperty
    a_den_mid: assert property (p_den_mid) // RL7
        else $error("denominator middle byte did not follow write");

    property p_dither;
        wr_en && addr == PSC_OFS_MOD |=>
            modulator_dither_select == $past(wdata[3:2]) ##1
            dither_active == ($past(modulator_dither_select) != 2'h3);
    endproperty
    a_dither: assert property (p_dither) // RL8
        else $error("dither select or flag wrong");

    property p_order;
        ##1 frac_mode == ($past(modulator_order) != 2'h0);
    endproperty
    a_order: assert property (p_order) // RL9
        else $error("fractional mode flag does not match order");

    property p_rst_mod;
        first_q |-> modulator_dither_select == 2'h3 &&
            modulator_order == 2'h0 && loop_filter_r2_code == 6'h24;
    endproperty
    a_rst_mod: assert property (p_rst_mod) // RL10
        else $error("modulator or R2 reset value wrong");

    property p_r2_rsvd;
        wr_en && addr == PSC_OFS_LFR2 ##1 rd_en && addr == PSC_OFS_LFR2
            |=> rdata == {2'b00, $past(wdata[5:0], 2)};
    endproperty
    a_r2_rsvd: assert property (p_r2_rsvd) // RL10
        else $error("R2 readback wrong");

    property p_unmapped;
        rd_en && !(|hit) |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) // RL11
        else $error("unmapped read not zero");

    property p_idle_rd;
        !rd_en |=> rdata == 8'h00;
    endproperty
    a_idle_rd: assert property (p_idle_rd) // RL11
        else $error("read data not zero outside read reply");

endmodule : psc_pll_regs
`default_nettype wire

// ---- psc_pkg.sv ----
/*
 * Shared constants for the PLL synthesizer configuration register bank:
 * byte offsets, field positions, reset values, write masks and codes.
 * Assumes an 8-bit register port with byte-wide registers.
 */
package psc_pkg;

    // bus and bank geometry
    localparam int PSC_AW = 8;
    localparam int PSC_DW = 8;
    localparam int PSC_NREG = 11;

    // register indexes inside the bank
    localparam int PSC_R_DBLCP = 0;
    localparam int PSC_R_NHI = 1;
    localparam int PSC_R_NLO = 2;
    localparam int PSC_R_NUM2 = 3;
    localparam int PSC_R_NUM1 = 4;
    localparam int PSC_R_NUM0 = 5;
    localparam int PSC_R_DEN2 = 6;
    localparam int PSC_R_DEN1 = 7;
    localparam int PSC_R_DEN0 = 8;
    localparam int PSC_R_MOD = 9;
    localparam int PSC_R_LFR2 = 10;

    // register offsets
    localparam logic [7:0] PSC_OFS_DBLCP = 8'h39;
    localparam logic [7:0] PSC_OFS_NHI = 8'h3A;
    localparam logic [7:0] PSC_OFS_NLO = 8'h3B;
    localparam logic [7:0] PSC_OFS_NUM2 = 8'h3C;
    localparam logic [7:0] PSC_OFS_NUM1 = 8'h3D;
    localparam logic [7:0] PSC_OFS_NUM0 = 8'h3E;
    localparam logic [7:0] PSC_OFS_DEN2 = 8'h3F;
    localparam logic [7:0] PSC_OFS_DEN1 = 8'h40;
    localparam logic [7:0] PSC_OFS_DEN0 = 8'h41;
    localparam logic [7:0] PSC_OFS_MOD = 8'h42;
    localparam logic [7:0] PSC_OFS_LFR2 = 8'h43;

    // field positions
    localparam int PSC_DBL_BIT = 4;
    localparam int PSC_CP_MSB = 3;
    localparam int PSC_NHI_MSB = 3;
    localparam int PSC_TOP_MSB = 5;
    localparam int PSC_DTH_MSB = 3;
    localparam int PSC_DTH_LSB = 2;
    localparam int PSC_ORD_MSB = 1;
    localparam int PSC_R2_MSB = 5;

    // reset values
    localparam logic [7:0] PSC_RST_DBLCP = 8'h18;
    localparam logic [7:0] PSC_RST_NHI = 8'h00;
    localparam logic [7:0] PSC_RST_NLO = 8'h66;
    localparam logic [7:0] PSC_RST_ZERO = 8'h00;
    localparam logic [7:0] PSC_RST_MOD = 8'h0C;
    localparam logic [7:0] PSC_RST_LFR2 = 8'h24;

    // writable bits; the rest read as zero
    localparam logic [7:0] PSC_MSK_DBLCP = 8'h3F;
    localparam logic [7:0] PSC_MSK_NIB = 8'h0F;
    localparam logic [7:0] PSC_MSK_SIX = 8'h3F;
    localparam logic [7:0] PSC_MSK_FULL = 8'hFF;

    // charge-pump current in units of 0.1 mA
    localparam logic [3:0] PSC_CP_STEP_MAX = 4'h7;
    localparam logic [3:0] PSC_CP_CODE_HI = 4'h8;
    localparam logic [6:0] PSC_CP_STEP = 7'h04;
    localparam logic [6:0] PSC_CP_HI = 7'h40;

    // divide ratio floor
    localparam logic [11:0] PSC_DIV_MIN = 12'h001;

    // modulator modes
    typedef enum logic [1:0] {
        PSC_DTH_WEAK = 2'h0,
        PSC_DTH_MED = 2'h1,
        PSC_DTH_STRONG = 2'h2,
        PSC_DTH_OFF = 2'h3
    } psc_dither_t;

    typedef enum logic [1:0] {
        PSC_ORD_INT = 2'h0,
        PSC_ORD_1ST = 2'h1,
        PSC_ORD_2ND = 2'h2,
        PSC_ORD_3RD = 2'h3
    } psc_order_t;

    // per-register tables, indexed as above
    localparam logic [7:0] PSC_OFS [PSC_NREG] = '{
        PSC_OFS_DBLCP, PSC_OFS_NHI, PSC_OFS_NLO, PSC_OFS_NUM2,
        PSC_OFS_NUM1, PSC_OFS_NUM0, PSC_OFS_DEN2, PSC_OFS_DEN1,
        PSC_OFS_DEN0, PSC_OFS_MOD, PSC_OFS_LFR2};
    localparam logic [7:0] PSC_RST [PSC_NREG] = '{
        PSC_RST_DBLCP, PSC_RST_NHI, PSC_RST_NLO, PSC_RST_ZERO,
        PSC_RST_ZERO, PSC_RST_ZERO, PSC_RST_ZERO, PSC_RST_ZERO,
        PSC_RST_ZERO, PSC_RST_MOD, PSC_RST_LFR2};
    localparam logic [7:0] PSC_MSK [PSC_NREG] = '{
        PSC_MSK_DBLCP, PSC_MSK_NIB, PSC_MSK_FULL, PSC_MSK_SIX,
        PSC_MSK_FULL, PSC_MSK_FULL, PSC_MSK_SIX, PSC_MSK_FULL,
        PSC_MSK_FULL, PSC_MSK_NIB, PSC_MSK_SIX};

endpackage : psc_pkg

// ---- psc_field_reg.sv ----
/*
 * One byte-wide configuration register with reset value and write mask.
 * Assumes a one-cycle write enable from the bank decoder.
 */
`timescale 1ns/1ps
`default_nettype none
module psc_field_reg #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // write side
    input wire logic we,
    input wire logic [7:0] wdata,
    // stored value
    output logic [7:0] q
);
    logic [7:0] val_q;
    logic [7:0] val_d;

    // masked bits never store, so they read as zero
    always_comb begin
        val_d = val_q;
        if (we) begin
            val_d = wdata & WR_MASK; // RL11
        end
    end

    // storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            val_q <= RST_VAL & WR_MASK;
        end else begin
            val_q <= val_d;
        end
    end

    assign q = val_q;
endmodule : psc_field_reg
`default_nettype wire

// ---- psc_div_decode.sv ----
/*
 * Registered decode of the divider code into an effective ratio and of
 * the charge-pump code into a current in 0.1 mA units.
 * Assumes codes come straight from the register bank.
 */
`timescale 1ns/1ps
`default_nettype none
module psc_div_decode (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // codes
    input wire logic [11:0] div_code,
    input wire logic [3:0] cp_code,
    // decoded values
    output logic [11:0] div_ratio,
    output logic [6:0] cp_current
);
    import psc_pkg::*;

    logic [11:0] ratio_q;
    logic [11:0] ratio_d;
    logic [6:0] cp_q;
    logic [6:0] cp_d;

    // codes 0 and 1 both divide by one; unlisted cp codes give no current
    always_comb begin
        ratio_d = div_code;
        if (div_code <= PSC_DIV_MIN) begin
            ratio_d = PSC_DIV_MIN; // RL3
        end
        cp_d = 7'h00;
        if (cp_code == PSC_CP_CODE_HI) begin
            cp_d = PSC_CP_HI; // RL2
        end else if (cp_code <= PSC_CP_STEP_MAX) begin
            cp_d = 7'({3'h0, cp_code} * PSC_CP_STEP); // RL2
        end
    end

    // output flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ratio_q <= 12'h000;
            cp_q <= 7'h00;
        end else begin
            ratio_q <= ratio_d;
            cp_q <= cp_d;
        end
    end

    assign div_ratio = ratio_q;
    assign cp_current = cp_q;
endmodule : psc_div_decode
`default_nettype wire

// ---- psc_pll_regs_tb.sv ----
/*
 * Self-checking bench for the pll configuration register bank.
 * Assumes the psc_pkg constants and the one-cycle strobe register port.
 */
`timescale 1ns/1ps
`default_nettype none
module psc_pll_regs_tb;
    import psc_pkg::*;

    logic clk, rstn, wr_en, rd_en;
    logic [7:0] addr, wdata, rdata;
    logic dbl, dth_act, frac_md;
    logic [3:0] cp_code;
    logic [6:0] cp_cur;
    logic [11:0] ndiv, nratio;
    logic [21:0] num, den;
    logic [1:0] dth, ord;
    logic [5:0] r2;
    int n_mismatch, checks_done, cyc;
    logic [7:0] e_rst [PSC_NREG] = '{8'h18, 8'h00, 8'h66, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h24};
    logic [7:0] e_msk [PSC_NREG] = '{8'h3F, 8'h0F, 8'hFF, 8'h3F, 8'hFF,
        8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h3F};
    logic [11:0] dv [7] = '{12'h000, 12'h001, 12'h002, 12'h0FF, 12'h100,
        12'hFFF, 12'h066};
    logic [7:0] r2v [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h30};
    logic [31:0] e;

    psc_pll_regs dut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .primary_ref_doubler_en(dbl), .cp_gain_code(cp_code),
        .cp_current(cp_cur), .int_feedback_divider(ndiv),
        .int_divide_ratio(nratio), .frac_numerator(num),
        .frac_denominator(den), .modulator_dither_select(dth),
        .modulator_order(ord), .dither_active(dth_act),
        .frac_mode(frac_md), .loop_filter_r2_code(r2)
    );

    // clock
    always #5 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: %s seen %0h expected %0h", $time, what,
                     seen, exp);
        end
    endtask : chk

    // one-cycle write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // one-cycle read, data taken in the following cycle
    task automatic rchk(input logic [7:0] a, input logic [7:0] ex,
                        input string what);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(32'(rdata), 32'(ex), what);
    endtask : rchk

    // let field and decoded outputs land
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        settle();
        chk(32'(dbl), 32'h1, "doubler reset");
        chk(32'(cp_code), 32'h8, "cp code reset");
        chk(32'(cp_cur), 32'h40, "cp current reset");
        chk(32'(nratio), 32'd102, "ratio reset");
        chk(32'(dth_act), 32'h0, "dither reset");
        chk(32'(frac_md), 32'h0, "order reset");
        chk(32'(r2), 32'h24, "r2 reset");
        for (int i = 0; i < PSC_NREG; i++)
            rchk(PSC_OFS[i], e_rst[i], "reset readback");
        @(posedge clk);
        #1;
        chk(32'(rdata), 32'h0, "rdata idle");
        $display("test reset values done");

        // all ones then all zeros, bits outside the write masks stay zero
        for (int i = 0; i < PSC_NREG; i++)
            wr(PSC_OFS[i], 8'hFF);
        for (int i = 0; i < PSC_NREG; i++)
            rchk(PSC_OFS[i], e_msk[i], "mask readback");
        chk(32'(num), 32'h3FFFFF, "num ones");
        chk(32'(den), 32'h3FFFFF, "den ones");
        chk(32'(ndiv), 32'hFFF, "div ones");
        for (int i = 0; i < PSC_NREG; i++)
            wr(PSC_OFS[i], 8'h00);
        wr(8'h38, 8'hFF);
        wr(8'h44, 8'hFF);
        rchk(8'h38, 8'h00, "unmapped low");
        rchk(8'h44, 8'h00, "unmapped high");
        for (int i = 0; i < PSC_NREG; i++)
            rchk(PSC_OFS[i], 8'h00, "zero readback");
        $display("test access masks done");

        // charge-pump codes
        for (int c = 0; c < 16; c++) begin
            wr(PSC_OFS_DBLCP, 8'(c));
            settle();
            e = (c >= 1 && c <= 7) ? 32'(c * 4) : (c == 8) ? 32'h40 : 32'h0;
            chk(32'(cp_cur), e, "cp current");
            chk(32'(cp_code), 32'(c), "cp code");
            chk(32'(dbl), 32'h0, "doubler off");
        end
        wr(PSC_OFS_DBLCP, 8'h10);
        settle();
        chk(32'(dbl), 32'h1, "doubler on");
        $display("test charge pump done");

        // divider codes, 0 and 1 both divide by one
        for (int i = 0; i < 7; i++) begin
            wr(PSC_OFS_NHI, {4'h0, dv[i][11:8]});
            wr(PSC_OFS_NLO, dv[i][7:0]);
            settle();
            e = (dv[i] < 12'h002) ? 32'h1 : 32'(dv[i]);
            chk(32'(ndiv), 32'(dv[i]), "div code");
            chk(32'(nratio), e, "div ratio");
        end
        $display("test divider done");

        // every dither and order combination
        for (int d = 0; d < 4; d++) begin
            for (int o = 0; o < 4; o++) begin
                wr(PSC_OFS_MOD, 8'(d * 4 + o));
                settle();
                chk(32'(dth), 32'(d), "dither sel");
                chk(32'(dth_act), 32'(d != 3), "dither act");
                chk(32'(ord), 32'(o), "order");
                chk(32'(frac_md), 32'(o != 0), "frac mode");
            end
        end
        $display("test modulator done");

        // fractional bytes land in their slices
        wr(PSC_OFS_NUM2, 8'hE5);
        wr(PSC_OFS_NUM1, 8'hA7);
        wr(PSC_OFS_NUM0, 8'h3C);
        wr(PSC_OFS_DEN2, 8'h1B);
        wr(PSC_OFS_DEN1, 8'h4D);
        wr(PSC_OFS_DEN0, 8'hF2);
        settle();
        chk(32'(num), 32'h25A73C, "numerator");
        chk(32'(den), 32'h1B4DF2, "denominator");
        rchk(PSC_OFS_NUM2, 8'h25, "num top");
        for (int i = 0; i < 6; i++) begin
            wr(PSC_OFS_LFR2, r2v[i]);
            settle();
            chk(32'(r2), 32'(r2v[i]), "r2 code");
        end
        $display("test fraction and r2 done");

        // write then read with no gap
        @(posedge clk);
        addr <= PSC_OFS_LFR2;
        wdata <= 8'hD1;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(32'(rdata), 32'h11, "back to back");
        // reset in mid-run
        wr(PSC_OFS_NLO, 8'h20);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        #1;
        chk(32'(ndiv), 32'h066, "div after reset");
        chk(32'(r2), 32'h24, "r2 after reset");
        @(posedge clk);
        rstn <= 1'b1;
        settle();
        chk(32'(cp_cur), 32'h40, "cp after reset");
        $display("test back to back and reset done");
        conclude();
    end

endmodule : psc_pll_regs_tb
`default_nettype wire
